/* File: common/can_lp_pkg.sv */
// Constants, register map and state types for the CAN low-power and bit-timing block
package can_lp_pkg;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] CFG_OFS    = 8'h04;
	localparam logic [7:0] TIMING_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0c;
	// Control register bits
	localparam int CTRL_SLEEP_REQ  = 0;
	localparam int CTRL_SOFT_RST   = 1;
	localparam int CTRL_STOP_WAIT  = 2;
	localparam int CTRL_WAKE_IE    = 3;
	localparam int CTRL_TLINK_EN   = 4;
	localparam int CTRL_W          = 5;
	// Config register bits
	localparam int CFG_WAKE_FILT   = 0;
	localparam int CFG_CLK_SEL     = 1;
	localparam int CFG_W           = 2;
	// Timing register fields
	localparam int PRESC_LSB = 0;
	localparam int PRESC_W   = 6;
	localparam int SEG1_LSB  = 8;
	localparam int SEG1_W    = 4;
	localparam int SEG2_LSB  = 12;
	localparam int SEG2_W    = 3;
	localparam int SJW_LSB   = 16;
	localparam int SJW_W     = 2;
	// Status register bits
	localparam int ST_SLEEP_ACK = 0;
	localparam int ST_SYNCED    = 1;
	localparam int ST_PWR_DOWN  = 2;
	localparam int ST_BUSOFF_HOLD = 3;
	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RST   = 5'h02;
	localparam logic [31:0]       TIMING_RST = 32'h0001_3300;
	// Bit-time constants
	localparam logic [3:0] IDLE_BITS   = 4'hb;
	localparam logic [3:0] SEG1_MIN_M1 = 4'h3;
	localparam logic [2:0] SEG2_MIN_M1 = 3'h1;
	// Controller mode
	typedef enum logic [4:0] {
		M_SOFT   = 5'b00001,
		M_SYNC   = 5'b00010,
		M_RUN    = 5'b00100,
		M_DRAIN  = 5'b01000,
		M_SLEEP  = 5'b10000
	} mode_t;
endpackage : can_lp_pkg

/* File: src/can_low_power_bit_timing.sv */
// CAN controller low-power sequencing, wake-up, timer link and bit timing
// Function
// - Queued transmissions finish before sleep entry
// - Current reception finishes before sleep entry
// - Idle controller sleeps at once
// - Sleep acknowledge held while asleep
// - Sleep stops quantum ticks, transmit recessive
// - Bus-off recovery count pauses in sleep
// - No receive buffer copy in sleep
// - No message abort during sleep
// - Wake on bus activity, clear, soft reset
// - Wait eleven recessive bits after wake
// - Deferred actions run on wake-up
// - Soft reset stops traffic immediately
// - Power-down in stop or wait-with-flag
// - Power-down aborts and forces recessive
// - No register access in power-down
// - Optional glitch filter on wake input
// - One-bit timer pulse after valid frame
// - Timer pulse gated by enable bit
// - Clock select: oscillator or doubled bus clock
// - Prescaler makes quantum; one-quantum sync
// - First segment four to sixteen quanta
// - Second segment two to eight quanta
// - Jump width one to four, minus-one code
// - Wake interrupt needs acknowledge and enable
// - Config writes blocked unless soft reset
`timescale 1ns/1ps
module can_low_power_bit_timing
	import can_lp_pkg::*;
#(
	parameter int FILT_LEN = 4            // Wake filter length in cycles
) (
	// Clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Processor power state
	input  wire logic        cpu_stop,
	input  wire logic        cpu_wait,
	// Protocol engine status
	input  wire logic        tx_pending,
	input  wire logic        rx_busy,
	input  wire logic        frame_valid,
	input  wire logic        bus_off,
	input  wire logic        crystal_osc_clock,
	input  wire logic        system_bus_clock,
	input  wire logic        clk2x_sel_ok,
	// Bus pins
	input  wire logic        bus_receive_pin,
	output logic             bus_transmit_pin,
	input  wire logic        engine_tx,
	// Engine controls
	output logic             protocol_run,
	output logic             engine_reset,
	output logic             rx_copy_allow,
	output logic             abort_allow,
	output logic             busoff_count_en,
	output logic             tq_tick,
	output logic             bit_tick,
	output logic             protocol_clock,
	output logic [1:0]       resync_jump_width,
	output logic             timer_capture,
	output logic             wake_irq
);
	// Register state
	logic [CTRL_W-1:0] ctrl_r;            // Control bits
	logic [CFG_W-1:0]  cfg_r;             // Config bits, locked
	logic [31:0]       timing_r;          // Bit timing, locked
	mode_t             mode_r;            // Controller mode
	logic              ack_r;             // Sleep acknowledge
	logic [1:0]        rx_sync_r;         // Receive pin synchroniser
	logic [1:0]        cs_sync_r;         // Stop pin synchroniser
	logic [1:0]        cw_sync_r;         // Wait pin synchroniser
	logic [$clog2(FILT_LEN+1)-1:0] filt_r; // Dominant run length
	logic [PRESC_W-1:0] presc_r;          // Prescaler count
	logic [4:0]        tq_r;              // Quantum in bit
	logic [3:0]        idle_r;            // Recessive bit count
	logic              tlink_r;           // Timer pulse
	logic [4:0]        tl_cnt_r;          // Quanta into timer pulse

	// Derived controls
	logic rxd, pwr_down, acc, wr, sleep_req, soft_rst, wake_evt;
	logic [4:0] bit_len;
	assign rxd        = rx_sync_r[1];
	// Power-down from processor state
	assign pwr_down   = cs_sync_r[1] | (cw_sync_r[1] & ctrl_r[CTRL_STOP_WAIT]);
	assign acc        = psel & penable & ~pwr_down;
	assign wr         = acc & pwrite;
	assign sleep_req  = ctrl_r[CTRL_SLEEP_REQ];
	assign soft_rst   = ctrl_r[CTRL_SOFT_RST];
	// Bit length: sync quantum plus both segments
	assign bit_len    = 5'(1) + 5'(timing_r[SEG1_LSB +: SEG1_W]) + 5'(1)
	                  + 5'(timing_r[SEG2_LSB +: SEG2_W]) + 5'(1);

	// Clamp a segment code into its allowed range
	function automatic logic [3:0] clamp_seg(input logic [3:0] v, input logic [3:0] lo);
		clamp_seg = (v < lo) ? lo : v;
	endfunction : clamp_seg

	// APB slave: always ready, error when powered down or unmapped
	assign pready  = 1'b1;
	assign pslverr = psel & penable & (pwr_down | (paddr > STATUS_OFS) | (paddr[1:0] != 2'b00));

	// Control register, sleep clear blocked before acknowledge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= CTRL_RST;
		end else if (clk_en && wr && paddr == CTRL_OFS) begin
			ctrl_r <= pwdata[CTRL_W-1:0];
			// Ignore clearing the request before acknowledge
			if (sleep_req && !pwdata[CTRL_SLEEP_REQ] && !ack_r) begin
				ctrl_r[CTRL_SLEEP_REQ] <= 1'b1;
			end
		end else if (clk_en && mode_r == M_SLEEP && wake_evt) begin
			// Bus wake drops the request, else the idle path re-enters sleep at once
			ctrl_r[CTRL_SLEEP_REQ] <= 1'b0;
		end
	end

	// Locked configuration and timing registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r    <= '0;
			timing_r <= TIMING_RST;
		end else if (clk_en && wr && soft_rst) begin
			if (paddr == CFG_OFS) begin
				cfg_r <= pwdata[CFG_W-1:0];
			end
			if (paddr == TIMING_OFS) begin
				timing_r <= '0;
				timing_r[PRESC_LSB +: PRESC_W] <= pwdata[PRESC_LSB +: PRESC_W];
				timing_r[SEG1_LSB +: SEG1_W] <= clamp_seg(pwdata[SEG1_LSB +: SEG1_W],
					SEG1_MIN_M1);
				timing_r[SEG2_LSB +: SEG2_W] <= 3'(clamp_seg({1'b0, pwdata[SEG2_LSB +: SEG2_W]},
					{1'b0, SEG2_MIN_M1}));
				timing_r[SJW_LSB +: SJW_W] <= pwdata[SJW_LSB +: SJW_W];
			end
		end
	end

	// Read mux
	always_comb begin
		prdata = '0;
		if (acc && !pwrite) begin
			case (paddr)
				CTRL_OFS:   prdata[CTRL_W-1:0] = ctrl_r;
				CFG_OFS:    prdata[CFG_W-1:0]  = cfg_r;
				TIMING_OFS: prdata = timing_r;
				STATUS_OFS: begin
					prdata[ST_SLEEP_ACK]   = ack_r;
					prdata[ST_SYNCED]      = (mode_r == M_RUN);
					prdata[ST_PWR_DOWN]    = pwr_down;
					prdata[ST_BUSOFF_HOLD] = bus_off & ack_r;
				end
				default:    prdata = '0;
			endcase
		end
	end

	// Pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_sync_r <= 2'b11;
			cs_sync_r <= 2'b00;
			cw_sync_r <= 2'b00;
		end else if (clk_en) begin
			rx_sync_r <= {rx_sync_r[0], bus_receive_pin};
			cs_sync_r <= {cs_sync_r[0], cpu_stop};
			cw_sync_r <= {cw_sync_r[0], cpu_wait};
		end
	end

	// Wake filter: dominant must persist when filtering is on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			filt_r <= '0;
		end else if (clk_en) begin
			if (rxd) begin
				filt_r <= '0;
			end else if (filt_r != ($clog2(FILT_LEN+1))'(FILT_LEN)) begin
				filt_r <= filt_r + 1'b1;
			end
		end
	end
	assign wake_evt = cfg_r[CFG_WAKE_FILT]
	                ? (filt_r == ($clog2(FILT_LEN+1))'(FILT_LEN))
	                : !rxd;

	// Protocol clock source choice; engine uses it with its own tolerance limits
	assign protocol_clock = cfg_r[CFG_CLK_SEL] ? (system_bus_clock & clk2x_sel_ok)
	                                           : crystal_osc_clock;

	// Prescaler and quantum counter, stopped in soft reset, sleep and power-down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_r   <= '0;
			tq_r      <= '0;
		end else if (clk_en) begin
			if (mode_r == M_SOFT || mode_r == M_SLEEP || pwr_down) begin
				presc_r <= '0;
				tq_r    <= '0;
			end else if (presc_r >= timing_r[PRESC_LSB +: PRESC_W]) begin
				presc_r   <= '0;
				tq_r      <= (tq_r + 5'(1) >= bit_len) ? 5'(0) : tq_r + 5'(1);
			end else begin
				presc_r <= presc_r + 1'b1;
			end
		end
	end
	assign tq_tick  = clk_en && (mode_r != M_SOFT) && (mode_r != M_SLEEP) && !pwr_down
	               && (presc_r >= timing_r[PRESC_LSB +: PRESC_W]);
	// Bit starts with a single sync quantum
	assign bit_tick = tq_tick && (tq_r == 5'(0));
	assign resync_jump_width = timing_r[SJW_LSB +: SJW_W];

	// Mode machine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r <= M_SOFT;
			idle_r <= '0;
		end else if (clk_en) begin
			if (soft_rst || pwr_down) begin
				mode_r <= M_SOFT;
				idle_r <= '0;
			end else begin
				case (mode_r)
					M_SOFT: begin
						mode_r <= M_SYNC;
						idle_r <= '0;
					end
					M_SYNC: begin
						if (sleep_req) begin
							mode_r <= M_SLEEP;
						end else if (bit_tick) begin
							idle_r <= rxd ? idle_r + 4'h1 : 4'h0;
							if (rxd && idle_r + 4'h1 == IDLE_BITS) begin
								mode_r <= M_RUN;
							end
						end
					end
					M_RUN: begin
						if (sleep_req) begin
							mode_r <= (tx_pending || rx_busy) ? M_DRAIN : M_SLEEP;
						end
					end
					M_DRAIN: begin
						if (!tx_pending && !rx_busy) begin
							mode_r <= M_SLEEP;
						end else if (!sleep_req) begin
							mode_r <= M_RUN;
						end
					end
					M_SLEEP: begin
						if (!sleep_req || wake_evt) begin
							mode_r <= M_SYNC;
							idle_r <= '0;
						end
					end
					default: mode_r <= M_SOFT;
				endcase
			end
		end
	end

	// Sleep acknowledge follows sleep mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_r <= 1'b0;
		end else if (clk_en) begin
			ack_r <= (mode_r == M_SLEEP) && !soft_rst && !pwr_down && sleep_req && !wake_evt;
		end
	end

	// Timer link pulse, one whole bit of quanta after a valid frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tlink_r  <= 1'b0;
			tl_cnt_r <= '0;
		end else if (clk_en) begin
			if (frame_valid && protocol_run) begin
				tlink_r  <= 1'b1;
				tl_cnt_r <= '0;
			end else if (engine_reset || mode_r == M_SLEEP) begin
				// Quanta stop here, so the pulse would otherwise hang high
				tlink_r <= 1'b0;
			end else if (tlink_r && tq_tick) begin
				// Counted in quanta: clearing at the next bit start could cut it short
				if (tl_cnt_r + 5'(1) >= bit_len) begin
					tlink_r <= 1'b0;
				end
				tl_cnt_r <= tl_cnt_r + 5'(1);
			end
		end
	end
	assign timer_capture = tlink_r & ctrl_r[CTRL_TLINK_EN];

	// Engine controls
	assign protocol_run     = (mode_r == M_RUN) || (mode_r == M_DRAIN);
	assign engine_reset     = (mode_r == M_SOFT) || soft_rst || pwr_down;
	// Deferred copy and abort resume once awake
	assign rx_copy_allow    = protocol_run;
	assign abort_allow      = protocol_run;
	assign busoff_count_en  = bus_off && (mode_r != M_SLEEP) && !engine_reset;
	// Transmit forced recessive outside active modes
	assign bus_transmit_pin = protocol_run ? engine_tx : 1'b1;
	assign wake_irq         = ack_r & ctrl_r[CTRL_WAKE_IE] & wake_evt;

	// Checks
	chk_ack_sleep: assert property (@(posedge pclk) disable iff (!presetn)
		ack_r |-> $past(mode_r) == M_SLEEP) else $error("ack without sleep");
	chk_tx_recess: assert property (@(posedge pclk) disable iff (!presetn)
		!protocol_run |-> bus_transmit_pin) else $error("tx not recessive");
	chk_pd_soft: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && pwr_down |=> mode_r == M_SOFT) else $error("no stop on power-down");
	chk_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
		wake_irq |-> ack_r && ctrl_r[CTRL_WAKE_IE]) else $error("bad wake irq");
	chk_lock_cfg: assert property (@(posedge pclk) disable iff (!presetn)
		!soft_rst |=> $stable(timing_r)) else $error("timing changed unlocked");
	chk_drain_hold: assert property (@(posedge pclk) disable iff (!presetn)
		mode_r == M_DRAIN && (tx_pending || rx_busy) |=> mode_r != M_SLEEP)
		else $error("slept while busy");
	chk_seg_range: assert property (@(posedge pclk) disable iff (!presetn)
		timing_r[SEG1_LSB +: SEG1_W] >= SEG1_MIN_M1 && timing_r[SEG2_LSB +: SEG2_W] >= SEG2_MIN_M1)
		else $error("segment out of range");
	chk_busoff_hold: assert property (@(posedge pclk) disable iff (!presetn)
		mode_r == M_SLEEP |-> !busoff_count_en) else $error("bus-off counts in sleep");
	chk_idle_sleep: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && mode_r == M_RUN && sleep_req && !tx_pending && !rx_busy && !soft_rst
		&& !pwr_down |=> mode_r == M_SLEEP) else $error("idle sleep delayed");
	chk_wake_exit: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && mode_r == M_SLEEP && wake_evt && !soft_rst && !pwr_down
		|=> mode_r == M_SYNC) else $error("no wake on bus activity");
	chk_early_clr: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && wr && paddr == CTRL_OFS && sleep_req && !ack_r |=> sleep_req)
		else $error("early sleep clear taken");
	cov_sleep: cover property (@(posedge pclk) disable iff (!presetn) mode_r == M_SLEEP);
	cov_drain: cover property (@(posedge pclk) disable iff (!presetn) mode_r == M_DRAIN);
	cov_run:   cover property (@(posedge pclk) disable iff (!presetn) mode_r == M_RUN);
	cov_tlink: cover property (@(posedge pclk) disable iff (!presetn) timer_capture);
endmodule : can_low_power_bit_timing

/* File: verification/can_bus_model.sv */
// Behavioural CAN bus: wired-AND of our transmit pin and the other nodes
`timescale 1ns/1ps
module can_bus_model (
	// Clock
	input  wire logic pclk,
	// Node side
	input  wire logic bus_transmit_pin,
	input  wire logic other_dominant,
	// Receive side
	output logic      bus_receive_pin
);
	logic line_r; // Bus level seen by all nodes
	// Dominant from any node wins; one cycle of line delay
	always_ff @(posedge pclk) begin
		line_r <= bus_transmit_pin & ~other_dominant;
	end
	assign bus_receive_pin = line_r;
endmodule : can_bus_model

/* File: verification/tb_can_low_power_bit_timing.sv */
// Self-checking bench for the CAN low-power and bit-timing block
`timescale 1ns/1ps
module tb_can_low_power_bit_timing;
	import can_lp_pkg::*;
	// Clock, reset, register bus
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdata;
	// Engine status, power state, pins
	logic cpu_stop, cpu_wait, tx_pending, rx_busy, frame_valid, bus_off, engine_tx;
	logic xtal, sysclk, other_dominant, rx_pin, tx_pin, irq_seen;
	logic protocol_run, engine_reset, rx_copy_allow, abort_allow, busoff_count_en;
	logic tq_tick, bit_tick, protocol_clock, timer_capture, wake_irq;
	logic [1:0]  resync_jump_width;
	// Bookkeeping
	int          miscompares, checked, cycles, seed, n, i, k;
	logic [31:0] tv, p, s1, s2, j;

	can_low_power_bit_timing #(.FILT_LEN(4)) can_low_power_bit_timing_i (
		.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_stop(cpu_stop), .cpu_wait(cpu_wait),
		.tx_pending(tx_pending), .rx_busy(rx_busy), .frame_valid(frame_valid),
		.bus_off(bus_off), .crystal_osc_clock(xtal), .system_bus_clock(sysclk),
		.clk2x_sel_ok(1'b1), .bus_receive_pin(rx_pin), .bus_transmit_pin(tx_pin),
		.engine_tx(engine_tx), .protocol_run(protocol_run), .engine_reset(engine_reset),
		.rx_copy_allow(rx_copy_allow), .abort_allow(abort_allow),
		.busoff_count_en(busoff_count_en), .tq_tick(tq_tick), .bit_tick(bit_tick),
		.protocol_clock(protocol_clock), .resync_jump_width(resync_jump_width),
		.timer_capture(timer_capture), .wake_irq(wake_irq));
	can_bus_model can_bus_model_i (.pclk(pclk), .bus_transmit_pin(tx_pin),
		.other_dominant(other_dominant), .bus_receive_pin(rx_pin));

	// Bus clock, 50 ns period
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// Unrelated clock sources for the protocol clock mux
	always #13 xtal = ~xtal;
	always #10 sysclk = ~sysclk;

	// Hang guard and sticky wake interrupt capture (it may be a short pulse)
	always @(posedge pclk) begin
		cycles++;
		if (wake_irq === 1'b1)
			irq_seen <= 1'b1;
		if (cycles == 60000) begin
			miscompares++;
			end_sim;
		end
	end

	// Compare and report
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One APB transfer; holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Poll a status bit until it reaches a level (timeout guards the limit)
	task automatic poll(input int b, input logic v);
		repeat (1000) begin
			apb(1'b0, STATUS_OFS, 32'h0);
			if (rdata[b] === v)
				break;
		end
	endtask : poll
	// Cycles between two consecutive tick pulses
	task automatic per(input logic b, output int cnt);
		cnt = 0;
		do @(posedge pclk); while ((b ? bit_tick : tq_tick) !== 1'b1);
		do begin
			@(posedge pclk);
			cnt++;
		end while ((b ? bit_tick : tq_tick) !== 1'b1);
	endtask : per
	// Summary and verdict
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

	// Main sequence
	initial begin
		seed = 3;
		{presetn, psel, penable, pwrite, cpu_stop, cpu_wait, tx_pending, rx_busy} = '0;
		{frame_valid, bus_off, other_dominant, xtal, sysclk, irq_seen} = '0;
		engine_tx = 1'b1;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values and an unmapped address
		apb(1'b0, CTRL_OFS, 32'h0);
		chk(rdata[CTRL_W-1:0], CTRL_RST);
		apb(1'b0, TIMING_OFS, 32'h0);
		chk(rdata, TIMING_RST);
		apb(1'b0, 8'h10, 32'h0);
		chk(err, 1'b1);
		// Out-of-range segment codes are raised to their minimum
		apb(1'b1, TIMING_OFS, 32'h0);
		apb(1'b0, TIMING_OFS, 32'h0);
		chk(rdata, 32'h0000_1300);
		// Random legal bit timings, measured at the tick outputs
		for (i = 0; i < 3; i++) begin
			p = $unsigned($random(seed)) % 4;
			s1 = i == 0 ? 32'h3 : 3 + $unsigned($random(seed)) % 13;
			s2 = i == 0 ? 32'h7 : 1 + $unsigned($random(seed)) % 7;
			j = $unsigned($random(seed)) % 4;
			tv = (j << 16) | (s2 << 12) | (s1 << 8) | p;
			apb(1'b1, CTRL_OFS, 32'h2);
			apb(1'b1, TIMING_OFS, tv);
			apb(1'b0, TIMING_OFS, 32'h0);
			chk(rdata, tv);
			chk(resync_jump_width, j);
			apb(1'b1, CFG_OFS, {30'h0, i[0], 1'b0});
			// Look between clock source edges so neither toggles at the compare
			@(xtal or sysclk);
			#0.5;
			chk(protocol_clock, i[0] ? sysclk : xtal);
			apb(1'b1, CTRL_OFS, 32'h0);
			apb(1'b0, STATUS_OFS, 32'h0);
			chk(rdata[ST_SYNCED], 1'b0);
			per(1'b0, n);
			chk(n, p + 1);
			per(1'b1, n);
			chk(n, (p + 1) * (s1 + s2 + 3));
		end
		// Timing write outside soft reset, still syncing, is dropped
		apb(1'b1, TIMING_OFS, 32'h0002_2201);
		apb(1'b0, TIMING_OFS, 32'h0);
		chk(rdata, tv);
		poll(ST_SYNCED, 1'b1);
		chk(rdata[ST_SYNCED], 1'b1);
		// Timer link pulse, enabled then gated off
		for (k = 1; k >= 0; k--) begin
			apb(1'b1, CTRL_OFS, k ? 32'h10 : 32'h0);
			frame_valid <= 1'b1;
			@(posedge pclk);
			frame_valid <= 1'b0;
			@(posedge pclk);
			@(negedge pclk);
			chk(timer_capture, k[0]);
		end
		// Idle sleep, then wake by bus activity with the wake interrupt enabled
		bus_off <= 1'b1;
		apb(1'b1, CTRL_OFS, 32'h9);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk(rdata[ST_SLEEP_ACK], 1'b1);
		// Engine drives dominant while asleep: the pin must stay recessive
		engine_tx <= 1'b0;
		@(posedge pclk);
		chk({tx_pin, protocol_run, busoff_count_en}, 3'b100);
		chk({rx_copy_allow, abort_allow}, 2'b00);
		engine_tx <= 1'b1;
		other_dominant <= 1'b1;
		repeat (3) @(posedge pclk);
		other_dominant <= 1'b0;
		poll(ST_SLEEP_ACK, 1'b0);
		chk({rdata[ST_SLEEP_ACK], rdata[ST_SYNCED]}, 2'b00);
		chk(irq_seen, 1'b1);
		chk(busoff_count_en, 1'b1);
		bus_off <= 1'b0;
		apb(1'b1, CTRL_OFS, 32'h0);
		poll(ST_SYNCED, 1'b1);
		// Busy transmitter, then busy receiver: sleep waits; early clear refused
		for (k = 0; k < 2; k++) begin
			tx_pending <= (k == 0);
			rx_busy <= (k == 1);
			apb(1'b1, CTRL_OFS, 32'h1);
			apb(1'b1, CTRL_OFS, 32'h0);
			apb(1'b0, CTRL_OFS, 32'h0);
			chk(rdata[CTRL_SLEEP_REQ], 1'b1);
			apb(1'b0, STATUS_OFS, 32'h0);
			chk(rdata[ST_SLEEP_ACK], 1'b0);
			{tx_pending, rx_busy} <= 2'b00;
			poll(ST_SLEEP_ACK, 1'b1);
			chk(rdata[ST_SLEEP_ACK], 1'b1);
			apb(1'b1, CTRL_OFS, 32'h0);
			poll(ST_SLEEP_ACK, 1'b0);
			chk(rdata[ST_SLEEP_ACK], 1'b0);
			poll(ST_SYNCED, 1'b1);
		end
		// Sleep left by setting soft reset
		apb(1'b1, CTRL_OFS, 32'h1);
		apb(1'b1, CTRL_OFS, 32'h3);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk({rdata[ST_SLEEP_ACK], engine_reset}, 2'b01);
		// Power-down by wait with stop-in-wait, then by stop; plain wait keeps access
		// Request still set: leaving soft reset goes straight back to sleep
		apb(1'b1, CTRL_OFS, 32'h5);
		poll(ST_SLEEP_ACK, 1'b1);
		chk(rdata[ST_SLEEP_ACK], 1'b1);
		apb(1'b1, CTRL_OFS, 32'h4);
		poll(ST_SYNCED, 1'b1);
		chk(rdata[ST_SYNCED], 1'b1);
		for (k = 0; k < 3; k++) begin
			// Leave power-down before the write, or it is refused
			if (k == 1) begin
				cpu_wait <= 1'b0;
				repeat (4) @(posedge pclk);
				apb(1'b1, CTRL_OFS, 32'h0);
			end
			cpu_wait <= (k != 2);
			cpu_stop <= (k == 2);
			repeat (4) @(posedge pclk);
			apb(1'b0, STATUS_OFS, 32'h0);
			chk(err, k != 1);
			chk(tx_pin, 1'b1);
		end
		end_sim;
	end
endmodule : tb_can_low_power_bit_timing
